// ===== hw/smps_params.svh
`ifndef SMPS_PARAMS_SVH
`define SMPS_PARAMS_SVH
// =====================================
// reset vector address pair
`define SMPS_RESET_VEC_HI   16'hFFFE
`define SMPS_RESET_VEC_LO   16'hFFFF
// =====================================
// reset values
`define SMPS_FLAG_RST       1'b0
`define SMPS_PINS_RST       1'b0
`define SMPS_RTC_PRESCALE_SELECT_ZERO     4'h0
`endif

// ===== hw/smps_pkg.sv
package smps_pkg;
  // =====================================
  // power mode states
  typedef enum logic [1:0] {
    SMPS_RUN,
    SMPS_STOP3,
    SMPS_STOP2,
    SMPS_WAKE_RESET
  } smps_mode_t;
endpackage : smps_pkg

// ===== hw/smps_sequencer.sv
`include "smps_params.svh"
module smps_sequencer
  import smps_pkg::*;
#(
  parameter int PIN_W = 8
) (
  // clock and reset
  input  wire logic              clock_in,
  input  wire logic              reset_n_in,
  // stop request and mode selection
  input  wire logic              stop_instr_in,
  input  wire logic              stop_instruction_enable_in,
  input  wire logic              debug_mode_enable_in,
  input  wire logic              low_voltage_detect_enable_in,
  input  wire logic              low_voltage_detect_in_stop_enable_in,
  input  wire logic              deep_powerdown_select_in,
  // wake sources and supply monitor
  input  wire logic              reset_pin_n_in,
  input  wire logic              wake_irq_timer_clock_pin_in,
  input  wire logic              rtc_irq_in,
  input  wire logic              rtc_irq_enable_in,
  input  wire logic              supply_below_trip_in,
  // acknowledge strobe
  input  wire logic              powerdown_acknowledge_in,
  // module enables
  input  wire logic              adc_async_clock_enable_in,
  input  wire logic              comparator_bandgap_select_in,
  input  wire logic              internal_ref_clock_enable_in,
  input  wire logic              internal_ref_stop_enable_in,
  input  wire logic              external_ref_clock_enable_in,
  input  wire logic              external_ref_stop_enable_in,
  input  wire logic              osc_high_range_in,
  input  wire logic [3:0]        rtc_prescale_select_in,
  input  wire logic              usb_module_enable_in,
  input  wire logic              usb_transceiver_enable_in,
  // pin control
  input  wire logic [PIN_W-1:0]  port_value_in,
  input  wire logic [PIN_W-1:0]  periph_enable_in,
  input  wire logic [PIN_W-1:0]  periph_value_in,
  output logic      [PIN_W-1:0]  pin_value_out,
  // status
  output logic                   powerdown_recovery_flag_out,
  output logic                   powerdown_acknowledge_out,
  output logic                   pin_latch_closed_out,
  output logic                   in_stop2_out,
  output logic                   in_stop3_out,
  // power and clock controls
  output logic                   periph_clock_enable_out,
  output logic                   core_power_on_out,
  output logic                   ram_power_on_out,
  output logic                   module_reset_out,
  output logic                   lvd_reset_enable_out,
  output logic                   fetch_reset_vector_out,
  output logic      [15:0]       reset_vector_addr_out,
  output logic                   adc_on_out,
  output logic                   comparator_on_out,
  output logic                   internal_ref_on_out,
  output logic                   crystal_oscillator_on_out,
  output logic                   rtc_on_out,
  output logic                   usb_on_out
);

  // =====================================
  // mode state machine
  smps_mode_t mode;
  smps_mode_t next_mode;
  logic       deep_ok;
  logic       wake2;
  logic       rtc_keep;
  logic       lvd_in_stop;

  assign lvd_in_stop = low_voltage_detect_enable_in && low_voltage_detect_in_stop_enable_in;
  assign deep_ok     = !debug_mode_enable_in && deep_powerdown_select_in && !lvd_in_stop;
  assign wake2   = !reset_pin_n_in || !wake_irq_timer_clock_pin_in
                   || (rtc_irq_in && rtc_irq_enable_in && rtc_keep);

  always_comb begin
    next_mode = mode;
    unique case (mode)
      SMPS_RUN: begin
        if (stop_instr_in && stop_instruction_enable_in) begin
          next_mode = deep_ok ? SMPS_STOP2 : SMPS_STOP3;
        end
      end
      SMPS_STOP3: begin
        if (!reset_pin_n_in || (rtc_irq_in && rtc_irq_enable_in && rtc_keep)) begin
          next_mode = SMPS_RUN;
        end
      end
      SMPS_STOP2: begin
        if (wake2) begin
          next_mode = SMPS_WAKE_RESET;
        end
      end
      SMPS_WAKE_RESET: begin
        if (!supply_below_trip_in) begin
          next_mode = SMPS_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      mode <= SMPS_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  // =====================================
  // rtc prescale snapshot at stop entry
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      rtc_keep <= 1'b0;
    end else if (mode == SMPS_RUN && next_mode != SMPS_RUN) begin
      rtc_keep <= rtc_prescale_select_in != `SMPS_RTC_PRESCALE_SELECT_ZERO;
    end
  end

  // =====================================
  // recovery flag and pin latch
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      powerdown_recovery_flag_out <= `SMPS_FLAG_RST;
      pin_latch_closed_out        <= 1'b0;
    end else if (mode == SMPS_RUN && next_mode == SMPS_STOP2) begin
      pin_latch_closed_out        <= 1'b1;
    end else if (mode == SMPS_STOP2 && wake2) begin
      powerdown_recovery_flag_out <= 1'b1;
    end else if (powerdown_acknowledge_in && mode == SMPS_RUN) begin
      powerdown_recovery_flag_out <= 1'b0;
      pin_latch_closed_out        <= 1'b0;
    end
  end

  // acknowledge never reads back as one
  always_ff @(posedge clock_in) begin
    powerdown_acknowledge_out <= 1'b0;
  end

  // =====================================
  // pin outputs
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      pin_value_out <= {PIN_W{`SMPS_PINS_RST}};
    end else if (!pin_latch_closed_out && mode == SMPS_RUN) begin
      for (int i = 0; i < PIN_W; i++) begin
        pin_value_out[i] <= periph_enable_in[i] ? periph_value_in[i] : port_value_in[i];
      end
    end
  end

  // =====================================
  // power, clock and reset controls
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      in_stop2_out            <= 1'b0;
      in_stop3_out            <= 1'b0;
      periph_clock_enable_out <= 1'b1;
      core_power_on_out       <= 1'b1;
      ram_power_on_out        <= 1'b1;
      module_reset_out        <= 1'b1;
      lvd_reset_enable_out    <= 1'b1;
      fetch_reset_vector_out  <= 1'b0;
      reset_vector_addr_out   <= `SMPS_RESET_VEC_HI;
    end else begin
      in_stop2_out            <= next_mode == SMPS_STOP2;
      in_stop3_out            <= next_mode == SMPS_STOP3;
      periph_clock_enable_out <= next_mode == SMPS_RUN;
      core_power_on_out       <= next_mode != SMPS_STOP2;
      ram_power_on_out        <= 1'b1;
      module_reset_out        <= next_mode == SMPS_WAKE_RESET;
      lvd_reset_enable_out    <= next_mode == SMPS_WAKE_RESET ||
                                 lvd_reset_enable_out;
      fetch_reset_vector_out  <= mode == SMPS_WAKE_RESET && next_mode == SMPS_RUN;
      reset_vector_addr_out   <= `SMPS_RESET_VEC_HI;
    end
  end

  // =====================================
  // module keep-alive in stop
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      adc_on_out                <= 1'b1;
      comparator_on_out         <= 1'b1;
      internal_ref_on_out       <= 1'b1;
      crystal_oscillator_on_out <= 1'b1;
      rtc_on_out                <= 1'b1;
      usb_on_out                <= 1'b1;
    end else begin
      unique case (next_mode)
        SMPS_STOP3: begin
          adc_on_out                <= adc_async_clock_enable_in && lvd_in_stop;
          comparator_on_out         <= !comparator_bandgap_select_in || lvd_in_stop;
          internal_ref_on_out       <= internal_ref_clock_enable_in && internal_ref_stop_enable_in;
          crystal_oscillator_on_out <= external_ref_clock_enable_in && external_ref_stop_enable_in &&
                                       (!osc_high_range_in || lvd_in_stop);
          rtc_on_out                <= (mode == SMPS_RUN) ? (rtc_prescale_select_in != `SMPS_RTC_PRESCALE_SELECT_ZERO)
                                                          : rtc_keep;
          usb_on_out                <= usb_module_enable_in && usb_transceiver_enable_in;
        end
        SMPS_STOP2: begin
          adc_on_out                <= 1'b0;
          comparator_on_out         <= 1'b0;
          internal_ref_on_out       <= 1'b0;
          crystal_oscillator_on_out <= 1'b0;
          rtc_on_out                <= (mode == SMPS_RUN) ? (rtc_prescale_select_in != `SMPS_RTC_PRESCALE_SELECT_ZERO)
                                                          : rtc_keep;
          usb_on_out                <= 1'b0;
        end
        SMPS_RUN, SMPS_WAKE_RESET: begin
          adc_on_out                <= 1'b1;
          comparator_on_out         <= 1'b1;
          internal_ref_on_out       <= 1'b1;
          crystal_oscillator_on_out <= 1'b1;
          rtc_on_out                <= 1'b1;
          usb_on_out                <= 1'b1;
        end
      endcase
    end
  end

  // =====================================
  // assertions
  property p_stop2_select;
    @(posedge clock_in) disable iff (!reset_n_in)
      (mode == SMPS_RUN && stop_instr_in && stop_instruction_enable_in && !debug_mode_enable_in &&
       deep_powerdown_select_in && !(low_voltage_detect_enable_in && low_voltage_detect_in_stop_enable_in))
      |=> in_stop2_out;
  endproperty
  a_stop2_select: assert property (p_stop2_select) else $error("stop2 not selected");

  property p_stop_disabled;
    @(posedge clock_in) disable iff (!reset_n_in)
      (mode == SMPS_RUN && !stop_instruction_enable_in) |=> !in_stop2_out && !in_stop3_out;
  endproperty
  a_stop_disabled: assert property (p_stop_disabled) else $error("stop entered while disabled");

  property p_vector_fetch;
    @(posedge clock_in) disable iff (!reset_n_in)
      (mode == SMPS_WAKE_RESET && !supply_below_trip_in) |=> fetch_reset_vector_out;
  endproperty
  a_vector_fetch: assert property (p_vector_fetch) else $error("reset vector not fetched");

  property p_debug_blocks_stop2;
    @(posedge clock_in) disable iff (!reset_n_in)
      (mode == SMPS_RUN && stop_instr_in && stop_instruction_enable_in && debug_mode_enable_in)
      |=> in_stop3_out;
  endproperty
  a_debug_blocks_stop2: assert property (p_debug_blocks_stop2) else $error("debug should force stop3");

  property p_latch_on_entry;
    @(posedge clock_in) disable iff (!reset_n_in)
      $rose(in_stop2_out) |-> pin_latch_closed_out;
  endproperty
  a_latch_on_entry: assert property (p_latch_on_entry) else $error("pins not latched in stop2");

  property p_pins_hold;
    @(posedge clock_in) disable iff (!reset_n_in)
      pin_latch_closed_out && $past(pin_latch_closed_out) |-> $stable(pin_value_out);
  endproperty
  a_pins_hold: assert property (p_pins_hold) else $error("pins changed while latched");

  property p_wake_flag;
    @(posedge clock_in) disable iff (!reset_n_in)
      (mode == SMPS_STOP2 && !wake_irq_timer_clock_pin_in) |=> powerdown_recovery_flag_out && module_reset_out;
  endproperty
  a_wake_flag: assert property (p_wake_flag) else $error("wake did not set flag");

  property p_ack_clears;
    @(posedge clock_in) disable iff (!reset_n_in)
      (mode == SMPS_RUN && powerdown_acknowledge_in && next_mode == SMPS_RUN)
      |=> !powerdown_recovery_flag_out && !pin_latch_closed_out;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear");

  property p_clock_gated;
    @(posedge clock_in) disable iff (!reset_n_in)
      (in_stop2_out || in_stop3_out) |-> !periph_clock_enable_out;
  endproperty
  a_clock_gated: assert property (p_clock_gated) else $error("peripheral clock in stop");

  property p_ack_reads_zero;
    @(posedge clock_in) disable iff (!reset_n_in)
      powerdown_acknowledge_in |=> !powerdown_acknowledge_out;
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("ack read as one");

  property p_reset_hold;
    @(posedge clock_in) disable iff (!reset_n_in)
      (mode == SMPS_WAKE_RESET && supply_below_trip_in) |=> module_reset_out;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("released below trip");

endmodule : smps_sequencer

// ===== verif/smps_wake_model.sv
// =====================================
// wake pins, rtc interrupt and supply monitor beside the sequencer
module smps_wake_model
  import smps_pkg::*;
(
  // requests from the bench
  input  wire logic clock_in,
  input  wire logic wake_req_in,
  input  wire logic rst_req_in,
  input  wire logic rtc_req_in,
  input  wire logic supply_low_in,
  // pins and sources towards the sequencer
  output logic      wake_pin_out,
  output logic      reset_pin_n_out,
  output logic      rtc_irq_out,
  output logic      below_trip_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // wake pin is an input pulled high, low only while waking
  assign wake_pin_out    = ~wake_req_in;
  assign reset_pin_n_out = ~rst_req_in;
  assign rtc_irq_out     = rtc_req_in;
  assign below_trip_out  = supply_low_in;
endmodule : smps_wake_model

// ===== verif/tb_top.sv
`include "smps_params.svh"
module tb_top
  import smps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // =====================================
  // signals
  logic        clk, rst_n, stop_i, stop_en, dbg, low_voltage_detector, pd_sel, rtc_en, ack, rst_pin_n, wake_pin, rtc_irq, below;
  logic        lvds;
  logic        wake_req, rst_req, rtc_req, supply_low, adc_as, cmp_bg, ir_clk, ir_st, er_clk, er_st, hi_rng;
  logic        usb_en, phy_en, flag, ack_o, latch, s2, s3, pclk, core, ram, mrst, lvdr, fetch;
  logic        adc_on, cmp_on, ir_on, osc_on, rtc_on, usb_on;
  logic [3:0]  rtc_prescale_select;
  logic [7:0]  port_v, per_en, per_v, pins;
  logic [15:0] vec;
  logic [12:0] cfg [3] = '{13'h1520, 13'h1ff1, 13'h1ff8};
  int          err_total, total_checks, fetch_seen, i, j;
  // =====================================
  // instances
  smps_wake_model i_wake (.clock_in(clk), .wake_req_in(wake_req), .rst_req_in(rst_req), .rtc_req_in(rtc_req),
    .supply_low_in(supply_low), .wake_pin_out(wake_pin), .reset_pin_n_out(rst_pin_n), .rtc_irq_out(rtc_irq),
    .below_trip_out(below));
  smps_sequencer #(.PIN_W(8)) i_dut (.clock_in(clk), .reset_n_in(rst_n), .stop_instr_in(stop_i),
    .stop_instruction_enable_in(stop_en), .debug_mode_enable_in(dbg), .low_voltage_detect_enable_in(low_voltage_detector),
    .low_voltage_detect_in_stop_enable_in(lvds), .deep_powerdown_select_in(pd_sel), .reset_pin_n_in(rst_pin_n),
    .wake_irq_timer_clock_pin_in(wake_pin), .rtc_irq_in(rtc_irq), .rtc_irq_enable_in(rtc_en),
    .supply_below_trip_in(below), .powerdown_acknowledge_in(ack), .adc_async_clock_enable_in(adc_as),
    .comparator_bandgap_select_in(cmp_bg), .internal_ref_clock_enable_in(ir_clk), .internal_ref_stop_enable_in(ir_st),
    .external_ref_clock_enable_in(er_clk), .external_ref_stop_enable_in(er_st), .osc_high_range_in(hi_rng),
    .rtc_prescale_select_in(rtc_prescale_select), .usb_module_enable_in(usb_en), .usb_transceiver_enable_in(phy_en),
    .port_value_in(port_v), .periph_enable_in(per_en), .periph_value_in(per_v), .pin_value_out(pins),
    .powerdown_recovery_flag_out(flag), .powerdown_acknowledge_out(ack_o), .pin_latch_closed_out(latch),
    .in_stop2_out(s2), .in_stop3_out(s3), .periph_clock_enable_out(pclk), .core_power_on_out(core),
    .ram_power_on_out(ram), .module_reset_out(mrst), .lvd_reset_enable_out(lvdr), .fetch_reset_vector_out(fetch),
    .reset_vector_addr_out(vec), .adc_on_out(adc_on), .comparator_on_out(cmp_on), .internal_ref_on_out(ir_on),
    .crystal_oscillator_on_out(osc_on), .rtc_on_out(rtc_on), .usb_on_out(usb_on));
  // =====================================
  // clock, fetch counter and guard
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (fetch === 1'b1) fetch_seen++;
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    end_sim();
  end
  // =====================================
  // tasks
  task step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task do_stop;
    stop_i = 1'b1;
    step(1);
    stop_i = 1'b0;
    step(1);
  endtask : do_stop
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // =====================================
  // sequence
  initial begin
    {stop_i, stop_en, dbg, low_voltage_detector, lvds, pd_sel, rtc_en, ack, wake_req, rst_req, rtc_req, supply_low} = '0;
    {adc_as, cmp_bg, ir_clk, ir_st, er_clk, er_st, hi_rng, usb_en, phy_en, rtc_prescale_select} = '0;
    {port_v, per_en, per_v} = '0;
    rst_n = 1'b0;
    step(4);
    rst_n = 1'b1;
    step(2);
    chk("flag", flag, 16'h0000);
    chk("latch", latch, 16'h0000);
    chk("pclk", pclk, 16'h0001);
    chk("ack", ack_o, 16'h0000);
    pd_sel = 1'b1;
    do_stop;
    chk("stop off", {s2, s3}, 16'h0000);
    stop_en = 1'b1;
    for (i = 0; i < 3; i++) begin
      {dbg, low_voltage_detector, lvds, pd_sel} = (i == 0) ? 4'b1001 : (i == 1) ? 4'b0111 : 4'b0000;
      {adc_as, cmp_bg, ir_clk, ir_st, er_clk, er_st, hi_rng, usb_en, phy_en, rtc_prescale_select} = cfg[i];
      port_v = 8'h3c;
      step(2);
      chk("run pins", pins, 16'h003c);
      do_stop;
      port_v = 8'hc3;
      step(2);
      chk("stop3", {s2, s3}, 16'h0001);
      chk("held pins", pins, 16'h003c);
      chk("pclk3", pclk, 16'h0000);
      chk("adc", adc_on, adc_as & low_voltage_detector & lvds);
      if (cmp_bg) chk("cmp", cmp_on, low_voltage_detector & lvds);
      chk("iref", ir_on, ir_clk & ir_st);
      chk("osc", osc_on, er_clk & er_st & (!hi_rng | (low_voltage_detector & lvds)));
      chk("rtc3", rtc_on, rtc_prescale_select != 4'h0);
      chk("usb", usb_on, usb_en & phy_en);
      rtc_en = (i != 0);
      rtc_req = (i != 0);
      rst_req = (i == 0);
      step(2);
      {rtc_req, rtc_en, rst_req} = '0;
      step(2);
      chk("stop3 exit", {s3, pclk}, 16'h0001);
    end
    for (j = 0; j < 3; j++) begin
      {dbg, low_voltage_detector, lvds, pd_sel} = (j == 1) ? 4'b0101 : 4'b0001;
      rtc_prescale_select = j[3:0];
      per_en = 8'h00;
      port_v = 8'h5a;
      step(2);
      do_stop;
      port_v = 8'h00;
      supply_low = 1'b1;
      step(2);
      chk("stop2", {s2, s3}, 16'h0002);
      chk("latch2", latch, 16'h0001);
      chk("pins2", pins, 16'h005a);
      chk("pclk2", pclk, 16'h0000);
      chk("core", {core, ram}, 16'h0001);
      chk("rtc2", rtc_on, j != 0);
      chk("flag2", flag, 16'h0000);
      if (j == 2) begin
        rtc_req = 1'b1;
        step(3);
        chk("rtc masked", s2, 16'h0001);
        rtc_en = 1'b1;
      end
      else if (j == 0) wake_req = 1'b1;
      else rst_req = 1'b1;
      step(2);
      {wake_req, rst_req, rtc_req} = '0;
      step(2);
      chk("wake", {flag, s2}, 16'h0002);
      chk("mreset", {mrst, lvdr}, 16'h0003);
      fetch_seen = 0;
      step(5);
      chk("early fetch", fetch_seen, 16'h0000);
      supply_low = 1'b0;
      step(4);
      chk("fetch", fetch_seen, 16'h0001);
      chk("vector", vec, `SMPS_RESET_VEC_HI);
      chk("kept", {flag, latch}, 16'h0003);
      rtc_en = 1'b0;
      per_en = 8'h0f;
      per_v = 8'h05;
      port_v = 8'ha0;
      ack = 1'b1;
      step(1);
      ack = 1'b0;
      chk("ack read", ack_o, 16'h0000);
      step(1);
      chk("opened", {flag, latch}, 16'h0000);
      chk("reload", pins, 16'h00a5);
    end
    end_sim();
  end
endmodule : tb_top
